// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tea_pkg::*;
   localparam logic [31:0] IMPL = 32'h000ff80f;
   localparam logic [10:0] E0 [8] = '{11'h000, 11'h400, 11'h080, 11'h200,
                                      11'h040, 11'h002, 11'h000, 11'h004};
   localparam logic [10:0] E1 [8] = '{11'h000, 11'h400, 11'h001, 11'h100,
                                      11'h020, 11'h018, 11'h018, 11'h004};
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        timer_event_in_zero = 1'b0, timer_event_in_one = 1'b0;
   logic [19:0] irq_flags = 20'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq_req, restart_pulse, start_pulse, stop_pulse;
   logic        tally_each_event, inc_pulse, step_down_pulse, count_active;
   logic        step_down, capture_slot_zero, capture_slot_one, fault_pulse;
   logic [10:0] pv;
   logic [31:0] seed = 32'h0000ba67, m = 32'h0;
   int          n_errors = 0, checked = 0;
   assign pv = {restart_pulse, start_pulse, stop_pulse, tally_each_event,
                inc_pulse, step_down_pulse, capture_slot_zero,
                capture_slot_one, fault_pulse, count_active, step_down};
   always #20 core_clk = ~core_clk;
   timer_event_action_irq_mask dut (.core_clk, .nrst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timer_event_in_zero, .timer_event_in_one, .irq_flags, .irq_req,
      .restart_pulse, .start_pulse, .stop_pulse, .tally_each_event,
      .inc_pulse, .step_down_pulse, .count_active, .step_down,
      .capture_slot_zero, .capture_slot_one, .fault_pulse);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                      input string s);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v,
                         output logic [1:0] r);
      int   n;
      logic ta, tw, tb;
      n = 0;
      tb = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      // sample at the falling edge: same values the next rising edge sees
      while (!tb && n < 50) begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         n++;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (!tb) n_errors++;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] r);
      int   n;
      logic ta, tb;
      n = 0;
      tb = 1'b0;
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!tb && n < 50) begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         v = s_axi_rdata;
         r = s_axi_rresp;
         n++;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (!tb) n_errors++;
   endtask
   task automatic ev(input logic sel, input logic [2:0] c);
      logic [10:0] hi, all, e;
      int          tot, lvl;
      hi = 11'h0;
      all = 11'h0;
      tot = 0;
      lvl = 0;
      e = sel ? E1[c] : E0[c];
      wr_reg(OFF_EVENT_CTRL, 32'h0000c000 | (sel ? {26'h0, c, 3'h0}
                                                 : {29'h0, c}), rs);
      @(posedge core_clk);
      if (sel) timer_event_in_one <= 1'b1;
      else timer_event_in_zero <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         all |= pv;
         tot += $countones(pv[10:2]);
         lvl += int'(pv[1] | pv[0]);
         if (i < 5) hi |= pv;
         @(posedge core_clk);
         if (i == 4) timer_event_in_one <= 1'b0;
         if (i == 4) timer_event_in_zero <= 1'b0;
      end
      cmp(32'(all), 32'(e), "action outputs");
      cmp(32'(tot), 32'($countones(e[10:2])), "pulse count");
      // input is sampled high at five edges, so a level output spans five
      cmp(32'(lvl), (e[1:0] != 2'h0) ? 32'h5 : 32'h0, "level span");
      cmp(32'(hi & 11'h018), (sel && c == 3'h6) ? 32'h8 : 32'(e & 11'h010),
          "capture order");
      if (c == ACT_FAULT) begin
         rd_reg(OFF_ACTION_STATUS, rv, rs);
         cmp(rv & 32'h2, 32'h2, "fault seen");
         wr_reg(OFF_ACTION_STATUS, 32'h2, rs);
      end
   endtask
   task close_out;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      rd_reg(OFF_IRQ_MASK_CLEAR, rv, rs);
      cmp(rv, 32'h0, "mask reset");
      rd_reg(8'h3c, rv, rs);
      cmp({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read resp");
      cmp(rv, 32'h0, "unmapped read data");
      wr_reg(8'h3c, 32'hffffffff, rs);
      cmp({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write resp");
      // all ones through set: only implemented enables stick
      wr_reg(OFF_IRQ_MASK_SET, 32'hffffffff, rs);
      cmp({30'h0, rs}, {30'h0, RESP_OKAY}, "set resp");
      m = IMPL;
      rd_reg(OFF_IRQ_MASK_CLEAR, rv, rs);
      cmp(rv, m, "set all");
      wr_reg(OFF_IRQ_MASK_CLEAR, 32'h0, rs);
      rd_reg(OFF_IRQ_MASK_SET, rv, rs);
      cmp(rv, m, "clear zero");
      for (int k = 0; k < 24; k++) begin
         seed = lfsr(seed);
         d = seed;
         // bit 31 is unimplemented, so the port choice never skews the data
         m = d[31] ? (m | (d & IMPL)) : (m & ~d);
         wr_reg(d[31] ? OFF_IRQ_MASK_SET : OFF_IRQ_MASK_CLEAR, d, rs);
         rd_reg(d[31] ? OFF_IRQ_MASK_CLEAR : OFF_IRQ_MASK_SET, rv, rs);
         cmp(rv, m, "mask");
         seed = lfsr(seed);
         irq_flags <= seed[19:0];
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         cmp({31'h0, irq_req}, {31'h0, |(irq_flags & m[19:0])},
             "request");
      end
      for (int c = 0; c < 8; c++) ev(1'b0, 3'(c));
      for (int c = 0; c < 8; c++) ev(1'b1, 3'(c));
      // inverted idle pin reads active: the enabling write makes one edge
      wr_reg(OFF_EVENT_CTRL, 32'h00005004, rs);
      @(negedge core_clk);
      cmp({31'h0, inc_pulse}, 32'h1, "inverted edge");
      rd_reg(OFF_EVENT_CTRL, rv, rs);
      cmp(rv, 32'h00005004, "ctrl readback");
      close_out;
   end
endmodule
`default_nettype wire

// *** dv/tea_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module tea_checker
   import tea_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [MASK_W-1:0] irq_flags,
   input wire logic              irq_req,
   input wire logic              stop_pulse,
   input wire logic              capture_slot_zero,
   input wire logic              capture_slot_one,
   input wire logic              fault_pulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // no flag means no request, whatever the mask holds
   property p_irq_quiet;
      irq_flags == 20'h00000 |=> !irq_req;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("request raised with no flag");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer changed");
   // a refused read must not leak stale data onto the bus
   property p_ar_refuse;
      s_axi_rvalid && s_axi_rresp != RESP_OKAY |-> s_axi_rdata == 32'h0;
   endproperty
   a_ar_refuse: assert property (p_ar_refuse)
      else $error("refused read data not zero");
   property p_fault_once;
      fault_pulse |=> !fault_pulse;
   endproperty
   a_fault_once: assert property (p_fault_once)
      else $error("fault pulse too long");
   property p_stop_once;
      stop_pulse |=> !stop_pulse;
   endproperty
   a_stop_once: assert property (p_stop_once)
      else $error("stop pulse too long");
   // a rise and a fall cannot land in one cycle
   property p_cap_excl;
      !(capture_slot_zero && capture_slot_one);
   endproperty
   a_cap_excl: assert property (p_cap_excl)
      else $error("both capture slots at once");
endmodule
bind timer_event_action_irq_mask tea_checker u_chk (
   .core_clk(core_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq_flags(irq_flags), .irq_req(irq_req), .stop_pulse(stop_pulse),
   .capture_slot_zero(capture_slot_zero),
   .capture_slot_one(capture_slot_one), .fault_pulse(fault_pulse));
`default_nettype wire

// *** hw/action_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface action_if;
   logic restart;
   logic start;
   logic stop;
   logic tally;
   logic inc;
   logic dec;
   logic count_active;
   logic step_down;
   logic cap0_stb;
   logic cap1_stb;
   logic fault;
   modport src (output restart, start, stop, tally, inc, dec,
                count_active, step_down, cap0_stb, cap1_stb, fault);
   modport dst (input restart, start, stop, tally, inc, dec,
                count_active, step_down, cap0_stb, cap1_stb, fault);
endinterface
`default_nettype wire

// *** hw/event_action_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module event_action_decode
   import tea_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic [ACT_W-1:0] act0,
   input  wire logic [ACT_W-1:0] act1,
   input  wire logic             ev0,
   input  wire logic             ev1,
   action_if.src                 act
);
   typedef struct packed {
      logic ev0_d;
      logic ev1_d;
      logic restart;
      logic start;
      logic stop;
      logic tally;
      logic inc;
      logic dec;
      logic count_active;
      logic step_down;
      logic cap0_stb;
      logic cap1_stb;
      logic fault;
   } dec_state_t;

   dec_state_t st_r;
   dec_state_t st_nxt;

   always_comb begin
      logic rise0;
      logic rise1;
      logic fall1;
      rise0 = ev0 & ~st_r.ev0_d;
      rise1 = ev1 & ~st_r.ev1_d;
      fall1 = ~ev1 & st_r.ev1_d;
      st_nxt = '0;
      st_nxt.ev0_d = ev0;
      st_nxt.ev1_d = ev1;
      // code 0x0 and reserved 0x6 fall through with every pulse low
      unique case (act0)
         ACT_RESTART:    st_nxt.restart = rise0;
         ACT0_TALLY:     st_nxt.tally = rise0;
         ACT0_START:     st_nxt.start = rise0;
         ACT0_INC:       st_nxt.inc = rise0;
         ACT0_COUNT_ACT: st_nxt.count_active = ev0;
         ACT_FAULT:      st_nxt.fault = rise0;
         ACT_OFF, ACT0_RESERVED: ;
      endcase
      unique case (act1)
         ACT_RESTART:
            st_nxt.restart = st_nxt.restart | rise1;
         ACT1_DIR:       st_nxt.step_down = ev1;
         ACT1_STOP:      st_nxt.stop = rise1;
         ACT1_STEP_DOWN: st_nxt.dec = rise1;
         ACT1_PERIOD_WIDTH: begin
            st_nxt.cap0_stb = rise1;
            st_nxt.cap1_stb = fall1;
         end
         ACT1_WIDTH_PERIOD: begin
            st_nxt.cap1_stb = rise1;
            st_nxt.cap0_stb = fall1;
         end
         ACT_FAULT:
            st_nxt.fault = st_nxt.fault | rise1;
         ACT_OFF: ;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign act.restart      = st_r.restart;
   assign act.start        = st_r.start;
   assign act.stop         = st_r.stop;
   assign act.tally        = st_r.tally;
   assign act.inc          = st_r.inc;
   assign act.dec          = st_r.dec;
   assign act.count_active = st_r.count_active;
   assign act.step_down    = st_r.step_down;
   assign act.cap0_stb     = st_r.cap0_stb;
   assign act.cap1_stb     = st_r.cap1_stb;
   assign act.fault        = st_r.fault;
endmodule
`default_nettype wire

// *** hw/irq_mask_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_mask_regs
   import tea_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              clr_we,
   input  wire logic              set_we,
   input  wire logic [MASK_W-1:0] wbits,
   input  wire logic [MASK_W-1:0] impl,
   output logic      [MASK_W-1:0] mask
);
   typedef struct packed {
      logic [MASK_W-1:0] mask;
   } mask_state_t;

   mask_state_t st_r;
   mask_state_t st_nxt;

   // a single mask behind both ports, so either view shows every change
   always_comb begin
      st_nxt = st_r;
      if (clr_we) begin
         st_nxt.mask = st_r.mask & ~wbits;
      end
      if (set_we) begin
         st_nxt.mask = st_nxt.mask | wbits;
      end
      st_nxt.mask = st_nxt.mask & impl;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r.mask <= MASK_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mask = st_r.mask;
endmodule
`default_nettype wire

// *** hw/tea_pkg.sv ***
// Notes on behaviour
// - input one: 0x3 stops, 0x4 decrements counter
// - input one 0x5: period slot zero, width one
// - input one 0x6: period slot one, width zero
// - bits 2:0 select input zero action; 0x0 off
// - input zero: 0x1 restarts, 0x3 only starts
// - input zero: 0x2 tallies events, 0x4 increments
// - input zero 0x5 counts while event active
// - clear port: write one disables, zero ignored
// - clear and set ports share one mask
// - bits 19:16 are channel match enables
// - bits 15,14 are hard stop fault enables
// - bits 13,12 are recoverable fault enables
// - bit 11 is halt fault enable
// - bit 10 exists only on variant build
// - bit 3 error, bit 2 cycle enables
// - bit 1 restart, bit 0 wrap enables
// - clear port reads one while enabled
// - set port: write one enables, zero ignored
// - input one: 0x0 off, 0x1 restart, 0x2 direction
package tea_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MASK_W = 20;

   localparam logic [ADDR_W-1:0] OFF_EVENT_CTRL     = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_CLEAR = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK_SET   = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_ACTION_STATUS  = 8'h30;

   localparam int ACT0_LSB = 0;
   localparam int ACT1_LSB = 3;
   localparam int ACT_W    = 3;
   localparam int INV0_BIT = 12;
   localparam int INV1_BIT = 13;
   localparam int EN0_BIT  = 14;
   localparam int EN1_BIT  = 15;
   localparam int STAT_DIR_BIT   = 0;
   localparam int STAT_FAULT_BIT = 1;

   localparam logic [ACT_W-1:0] ACT_OFF          = 3'h0;
   localparam logic [ACT_W-1:0] ACT_RESTART      = 3'h1;
   localparam logic [ACT_W-1:0] ACT0_TALLY       = 3'h2;
   localparam logic [ACT_W-1:0] ACT0_START       = 3'h3;
   localparam logic [ACT_W-1:0] ACT0_INC         = 3'h4;
   localparam logic [ACT_W-1:0] ACT0_COUNT_ACT   = 3'h5;
   localparam logic [ACT_W-1:0] ACT0_RESERVED    = 3'h6;
   localparam logic [ACT_W-1:0] ACT1_DIR         = 3'h2;
   localparam logic [ACT_W-1:0] ACT1_STOP        = 3'h3;
   localparam logic [ACT_W-1:0] ACT1_STEP_DOWN   = 3'h4;
   localparam logic [ACT_W-1:0] ACT1_PERIOD_WIDTH = 3'h5;
   localparam logic [ACT_W-1:0] ACT1_WIDTH_PERIOD = 3'h6;
   localparam logic [ACT_W-1:0] ACT_FAULT        = 3'h7;

   // enable bits: 19:16 channels, 15:11 faults, 10 variant, 3:0 counter
   localparam logic [MASK_W-1:0] MASK_BASE_IMPL   = 20'hff80f;
   localparam logic [MASK_W-1:0] MASK_REFRESH_BIT = 20'h00400;
   localparam logic [MASK_W-1:0] MASK_RESET       = 20'h00000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/timer_event_action_irq_mask.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module timer_event_action_irq_mask
   import tea_pkg::*;
#(
   parameter bit HAS_REFRESH_FAULT = 1'b0
)(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              timer_event_in_zero,
   input  wire logic              timer_event_in_one,
   input  wire logic [MASK_W-1:0] irq_flags,
   output logic                   irq_req,
   output logic                   restart_pulse,
   output logic                   start_pulse,
   output logic                   stop_pulse,
   output logic                   tally_each_event,
   output logic                   inc_pulse,
   output logic                   step_down_pulse,
   output logic                   count_active,
   output logic                   step_down,
   output logic                   capture_slot_zero,
   output logic                   capture_slot_one,
   output logic                   fault_pulse
);
   localparam logic [MASK_W-1:0] MASK_IMPL =
      HAS_REFRESH_FAULT ? (MASK_BASE_IMPL | MASK_REFRESH_BIT)
                        : MASK_BASE_IMPL;

   typedef struct packed {
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] waddr;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic [ACT_W-1:0]  act0;
      logic [ACT_W-1:0]  act1;
      logic              inv0;
      logic              inv1;
      logic              en0;
      logic              en1;
      logic              fault_seen;
      logic              irq_req;
   } top_state_t;

   top_state_t        st_r;
   top_state_t        st_nxt;
   logic              clr_we;
   logic              set_we;
   logic [MASK_W-1:0] wbits;
   logic [MASK_W-1:0] mask;
   logic              ev0;
   logic              ev1;

   action_if act ();

   function automatic logic [DATA_W-1:0] lanes(input logic [3:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // a disabled input is held low so the decoder sees no edges from it
   assign ev0 = (timer_event_in_zero ^ st_r.inv0) & st_r.en0;
   assign ev1 = (timer_event_in_one ^ st_r.inv1) & st_r.en1;

   event_action_decode u_decode (
      .core_clk (core_clk),
      .nrst     (nrst),
      .act0     (st_r.act0),
      .act1     (st_r.act1),
      .ev0      (ev0),
      .ev1      (ev1),
      .act      (act)
   );

   irq_mask_regs u_mask (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clr_we   (clr_we),
      .set_we   (set_we),
      .wbits    (wbits),
      .impl     (MASK_IMPL),
      .mask     (mask)
   );

   // no new address or data is taken while a response is pending
   assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
   assign s_axi_wready  = ~st_r.w_got & ~st_r.bvalid;
   assign s_axi_arready = ~st_r.rvalid;

   always_comb begin
      logic              do_write;
      logic [DATA_W-1:0] wmasked;
      logic              fault_clr;
      st_nxt    = st_r;
      clr_we    = 1'b0;
      set_we    = 1'b0;
      fault_clr = 1'b0;
      wmasked   = st_r.wdata & lanes(st_r.wstrb);
      wbits     = wmasked[MASK_W-1:0];
      do_write  = st_r.aw_got & st_r.w_got & ~st_r.bvalid;

      if (s_axi_awvalid & s_axi_awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end

      if (do_write) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = RESP_OKAY;
         unique case (st_r.waddr)
            OFF_EVENT_CTRL: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.act0 = st_r.wdata[ACT0_LSB +: ACT_W];
                  st_nxt.act1 = st_r.wdata[ACT1_LSB +: ACT_W];
               end
               if (st_r.wstrb[1]) begin
                  st_nxt.inv0 = st_r.wdata[INV0_BIT];
                  st_nxt.inv1 = st_r.wdata[INV1_BIT];
                  st_nxt.en0  = st_r.wdata[EN0_BIT];
                  st_nxt.en1  = st_r.wdata[EN1_BIT];
               end
            end
            OFF_IRQ_MASK_CLEAR: clr_we = 1'b1;
            OFF_IRQ_MASK_SET:   set_we = 1'b1;
            OFF_ACTION_STATUS:  fault_clr = wmasked[STAT_FAULT_BIT];
            default:            st_nxt.bresp = RESP_SLVERR;
         endcase
      end

      if (st_r.bvalid & s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // a fault arriving with the clear keeps the flag set
      st_nxt.fault_seen = (st_r.fault_seen & ~fault_clr) | act.fault;

      if (st_r.rvalid & s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = RESP_OKAY;
         st_nxt.rdata  = '0;
         unique case (s_axi_araddr)
            OFF_EVENT_CTRL: begin
               st_nxt.rdata[ACT0_LSB +: ACT_W] = st_r.act0;
               st_nxt.rdata[ACT1_LSB +: ACT_W] = st_r.act1;
               st_nxt.rdata[INV0_BIT] = st_r.inv0;
               st_nxt.rdata[INV1_BIT] = st_r.inv1;
               st_nxt.rdata[EN0_BIT]  = st_r.en0;
               st_nxt.rdata[EN1_BIT]  = st_r.en1;
            end
            // both views read the one mask; holes read zero
            OFF_IRQ_MASK_CLEAR, OFF_IRQ_MASK_SET:
               st_nxt.rdata[MASK_W-1:0] = mask;
            OFF_ACTION_STATUS: begin
               st_nxt.rdata[STAT_DIR_BIT]   = act.step_down;
               st_nxt.rdata[STAT_FAULT_BIT] = st_r.fault_seen;
            end
            default: st_nxt.rresp = RESP_SLVERR;
         endcase
      end

      // bits 19:16 channels, 15:11 faults, 10 variant, 3:0 counter
      st_nxt.irq_req = |(irq_flags & mask);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp  = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata  = st_r.rdata;
   assign s_axi_rresp  = st_r.rresp;
   assign irq_req      = st_r.irq_req;

   assign restart_pulse     = act.restart;
   assign start_pulse       = act.start;
   assign stop_pulse        = act.stop;
   assign tally_each_event  = act.tally;
   assign inc_pulse         = act.inc;
   assign step_down_pulse   = act.dec;
   assign count_active      = act.count_active;
   assign step_down         = act.step_down;
   assign capture_slot_zero = act.cap0_stb;
   assign capture_slot_one  = act.cap1_stb;
   assign fault_pulse       = act.fault;
endmodule
`default_nettype wire
